// *** ilss_unit.sv ***
//Function
//- sign-bit count of bits matching sign
//- every result written one cycle later
//- OR, short constant sign-extended first
//- word saturating add clamps to 32-bit
//- long saturating add clamps to 40-bit
//- saturation sets clip flag one cycle after write-back
//- bit-field set forces field to ones
//- register form: high bits 0-4, low 5-9
//- left shift fills zeros from below
//- register amount from low six bits
//- immediate amount zero to thirty-one
//- amounts 40 to 63 shift 40
//- amount bits above five ignored
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module ilss_unit (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ilss_pkg::ILSS_ADDR_W-1:0] paddr,
	input wire logic [ilss_pkg::ILSS_DATA_W-1:0] pwdata,
	output logic [ilss_pkg::ILSS_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// issue port from instruction decode
	input wire logic iss_valid,
	input wire logic [3:0] iss_op,
	input wire logic iss_pred,
	input wire logic iss_imm,
	input wire logic [ilss_pkg::ILSS_CST_W-1:0] iss_cst_a,
	input wire logic [ilss_pkg::ILSS_CST_W-1:0] iss_cst_b,
	input wire logic [ilss_pkg::ILSS_LONG_W-1:0] first_source,
	input wire logic [ilss_pkg::ILSS_LONG_W-1:0] second_source,
	// write-back port to the register file
	output logic wb_valid,
	output logic wb_long,
	output logic [ilss_pkg::ILSS_LONG_W-1:0] wb_data,
	// clip flag of the control status register
	output logic clip_flag
);
	import ilss_pkg::*;

	// field mask with ones from lo through hi; empty when lo is above hi
	function automatic logic [31:0] ilss_field_mask(input logic [4:0] lo, input logic [4:0] hi);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < ILSS_WORD_W; i++) begin
			if ((5'(i) >= lo) && (5'(i) <= hi)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : ilss_field_mask

	// saturate a 33-bit word sum to 32 bits
	function automatic logic [31:0] ilss_sat_word(input logic [32:0] s);
		if (s[32] != s[31]) begin
			return s[32] ? ILSS_WORD_MIN : ILSS_WORD_MAX;
		end
		return s[31:0];
	endfunction : ilss_sat_word

	// control and status state
	logic csr_en_r;
	logic csr_clip_r;
	logic clip_pend_r;
	logic [31:0] issue_cnt_r;
	logic [31:0] sat_cnt_r;

	// write-back state
	logic wb_valid_r;
	logic wb_long_r;
	logic [39:0] wb_data_r;

	// apb answer state
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;

	// datapath nets
	ilss_op_t op;
	logic take;
	logic [31:0] first_source_w;
	logic [31:0] second_source_w;
	logic [31:0] cst_sext;
	logic [31:0] or_lhs;
	logic [32:0] sum_word;
	logic [40:0] sum_long;
	logic [39:0] shl_in;
	logic [5:0] shl_amt;
	logic [39:0] shl_out;
	logic [5:0] cnt_word;
	logic [5:0] cnt_long;
	logic [4:0] set_lo;
	logic [4:0] set_hi;
	logic [39:0] res_nxt;
	logic long_nxt;
	logic sat_nxt;
	logic wr_nxt;
	logic wr_go;

	// apb decode
	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic addr_hit;
	logic [31:0] rd_mux;

	// codes 12..15 fall to the default branch and write nothing
	assign op = ilss_op_t'(iss_op);
	assign first_source_w = first_source[31:0];
	assign second_source_w = second_source[31:0];

	// instructions are only taken while the unit is enabled
	assign take = iss_valid && csr_en_r;

	// an instruction that really lands at this edge; one net keeps counters in step
	assign wr_go = take && iss_pred && wr_nxt;

	// short constant as a signed word
	assign cst_sext = {{(ILSS_WORD_W-ILSS_CST_W){iss_cst_a[ILSS_CST_W-1]}}, iss_cst_a};
	assign or_lhs = iss_imm ? cst_sext : first_source_w;

	// word add widened by one bit so overflow stays visible
	assign sum_word = {or_lhs[31], or_lhs} + {second_source_w[31], second_source_w};
	// long add: first operand is a signed word widened to 41 bits
	assign sum_long = {{9{or_lhs[31]}}, or_lhs} + {second_source[39], second_source};

	// field bounds from constants or packed into the first source
	assign set_lo = iss_imm ? iss_cst_a : first_source_w[ILSS_SET_LO_LSB +: ILSS_CST_W];
	assign set_hi = iss_imm ? iss_cst_b : first_source_w[ILSS_SET_HI_LSB +: ILSS_CST_W];

	// immediate amount is 0..31; register amount keeps only six low bits
	assign shl_amt = iss_imm ? {1'b0, iss_cst_a} : first_source[ILSS_AMT_W-1:0];

	// shifter source widening depends on the form
	always_comb begin
		case (op)
			ILSS_OP_SHL_LONG: shl_in = second_source;
			ILSS_OP_SHL_UWORD_LONG: shl_in = {8'h00, second_source_w};
			default: shl_in = {{8{second_source_w[31]}}, second_source_w};
		endcase
	end

	ilss_shift_left u_shl (
		.value(shl_in),
		.amount(shl_amt),
		.result(shl_out)
	);

	ilss_sign_count #(.WIDTH(ILSS_WORD_W)) u_cnt_word (
		.value(second_source_w),
		.count(cnt_word)
	);

	ilss_sign_count #(.WIDTH(ILSS_LONG_W)) u_cnt_long (
		.value(second_source),
		.count(cnt_long)
	);

	// operation select; word results are zero-extended into the 40-bit bus
	always_comb begin
		res_nxt = 40'h0000000000;
		long_nxt = 1'b0;
		sat_nxt = 1'b0;
		wr_nxt = 1'b1;
		case (op)
			ILSS_OP_SIGN_COUNT: begin
				res_nxt = {34'h000000000, cnt_word};
			end
			ILSS_OP_SIGN_COUNT_LONG: begin
				// long form counts below bit 39, so up to 39
				res_nxt = {34'h000000000, cnt_long};
			end
			ILSS_OP_OR: begin
				res_nxt = {8'h00, or_lhs | second_source_w};
			end
			ILSS_OP_SATURATING_ADD_OP: begin
				res_nxt = {8'h00, ilss_sat_word(sum_word)};
				sat_nxt = sum_word[32] != sum_word[31];
			end
			ILSS_OP_SATURATING_ADD_OP_LONG: begin
				// overflow shows as bits 40 and 39 of the sum differing
				long_nxt = 1'b1;
				sat_nxt = sum_long[40] != sum_long[39];
				if (sat_nxt) begin
					res_nxt = sum_long[40] ? ILSS_LONG_MIN : ILSS_LONG_MAX;
				end else begin
					res_nxt = sum_long[39:0];
				end
			end
			ILSS_OP_CLAMP: begin
				// in range only when bits 39..31 all repeat the sign
				sat_nxt = (second_source[39:31] != {9{second_source[39]}});
				if (sat_nxt) begin
					res_nxt = {8'h00, second_source[39] ? ILSS_WORD_MIN : ILSS_WORD_MAX};
				end else begin
					res_nxt = {8'h00, second_source_w};
				end
			end
			ILSS_OP_SET: begin
				// upper 22 bits of the first source are ignored; only bits 9..0 give the bounds
				res_nxt = {8'h00, second_source_w | ilss_field_mask(set_lo, set_hi)};
			end
			ILSS_OP_SHL: begin
				// word shift keeps only the low 32 bits of the long shifter
				res_nxt = {8'h00, shl_out[31:0]};
			end
			ILSS_OP_SHL_LONG, ILSS_OP_SHL_UWORD_LONG: begin
				// unsigned word form arrives already zero-extended
				long_nxt = 1'b1;
				res_nxt = shl_out;
			end
			ILSS_OP_NOT: begin
				res_nxt = {8'h00, second_source_w ^ 32'hffffffff};
			end
			default: begin
				wr_nxt = 1'b0;
			end
		endcase
	end

	// write-back one cycle after issue; false predicate writes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_valid_r <= 1'b0;
			wb_long_r <= 1'b0;
			wb_data_r <= 40'h0000000000;
		end else begin
			wb_valid_r <= wr_go;
			if (wr_go) begin
				wb_long_r <= long_nxt;
				wb_data_r <= res_nxt;
			end
		end
	end

	// clip is raised the cycle after the saturated result is written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clip_pend_r <= 1'b0;
		end else begin
			clip_pend_r <= wr_go && sat_nxt;
		end
	end

	// apb phases; the answer is ready in the first access cycle
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && pready_r;
	assign apb_wr = apb_access && pwrite && addr_hit;

	always_comb begin
		addr_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			ILSS_OFF_CSR: begin
				rd_mux[ILSS_CSR_EN_BIT] = csr_en_r;
				rd_mux[ILSS_CSR_CLIP_BIT] = csr_clip_r;
			end
			ILSS_OFF_RES_LO: rd_mux = wb_data_r[31:0];
			ILSS_OFF_RES_HI: rd_mux = {24'h000000, wb_data_r[39:32]};
			ILSS_OFF_ISSUE_CNT: rd_mux = issue_cnt_r;
			ILSS_OFF_SAT_CNT: rd_mux = sat_cnt_r;
			default: addr_hit = 1'b0;
		endcase
	end

	// answer registers: data and error sampled in setup, shown in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= apb_setup;
			pslverr_r <= apb_setup && !addr_hit;
			if (apb_setup && !pwrite) begin
				prdata_r <= rd_mux;
			end else if (apb_access) begin
				prdata_r <= 32'h00000000;
			end
		end
	end

	// enable bit lets software make the unit drop issued instructions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_en_r <= ILSS_CSR_EN_RST;
		end else if (apb_wr && (paddr == ILSS_OFF_CSR)) begin
			csr_en_r <= pwdata[ILSS_CSR_EN_BIT];
		end
	end

	// sticky clip flag, write one to clear; a new saturation wins the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_clip_r <= ILSS_CSR_CLIP_RST;
		end else if (clip_pend_r) begin
			csr_clip_r <= 1'b1;
		end else if (apb_wr && (paddr == ILSS_OFF_CSR) && pwdata[ILSS_CSR_CLIP_BIT]) begin
			csr_clip_r <= 1'b0;
		end
	end

	// activity counters, wrap silently; written by software to any value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			issue_cnt_r <= 32'h00000000;
			sat_cnt_r <= 32'h00000000;
		end else begin
			if (apb_wr && (paddr == ILSS_OFF_ISSUE_CNT)) begin
				issue_cnt_r <= pwdata;
			end else if (wr_go) begin
				issue_cnt_r <= issue_cnt_r + 32'h00000001;
			end
			if (apb_wr && (paddr == ILSS_OFF_SAT_CNT)) begin
				sat_cnt_r <= pwdata;
			end else if (clip_pend_r) begin
				sat_cnt_r <= sat_cnt_r + 32'h00000001;
			end
		end
	end

	// every output comes straight from its register
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign wb_valid = wb_valid_r;
	assign wb_long = wb_long_r;
	assign wb_data = wb_data_r;
	assign clip_flag = csr_clip_r;

endmodule : ilss_unit

`default_nettype wire

// *** ilss_pkg.sv ***
package ilss_pkg;

	// operand and result widths
	localparam int ILSS_WORD_W = 32;
	localparam int ILSS_LONG_W = 40;
	localparam int ILSS_AMT_W = 6;
	localparam int ILSS_CST_W = 5;
	localparam int ILSS_CNT_W = 6;

	// apb geometry
	localparam int ILSS_ADDR_W = 12;
	localparam int ILSS_DATA_W = 32;

	// register byte offsets
	localparam logic [11:0] ILSS_OFF_CSR = 12'h000;
	localparam logic [11:0] ILSS_OFF_RES_LO = 12'h004;
	localparam logic [11:0] ILSS_OFF_RES_HI = 12'h008;
	localparam logic [11:0] ILSS_OFF_ISSUE_CNT = 12'h00c;
	localparam logic [11:0] ILSS_OFF_SAT_CNT = 12'h010;

	// control status register layout and reset values
	localparam int ILSS_CSR_EN_BIT = 0;
	localparam int ILSS_CSR_CLIP_BIT = 1;
	localparam logic ILSS_CSR_EN_RST = 1'b1;
	localparam logic ILSS_CSR_CLIP_RST = 1'b0;

	// register-form bit-field set: field high in bits 4..0, field low in bits 9..5
	localparam int ILSS_SET_HI_LSB = 0;
	localparam int ILSS_SET_LO_LSB = 5;

	// register shift amounts above this saturate to the cap
	localparam logic [5:0] ILSS_SHIFT_LAST = 6'h27;
	localparam logic [5:0] ILSS_SHIFT_CAP = 6'h28;

	// saturation bounds
	localparam logic [31:0] ILSS_WORD_MAX = 32'h7fffffff;
	localparam logic [31:0] ILSS_WORD_MIN = 32'h80000000;
	localparam logic [39:0] ILSS_LONG_MAX = 40'h7fffffffff;
	localparam logic [39:0] ILSS_LONG_MIN = 40'h8000000000;

	// operations accepted on the issue port
	typedef enum logic [3:0] {
		ILSS_OP_NOP = 4'b0000,
		ILSS_OP_SIGN_COUNT = 4'b0001,
		ILSS_OP_SIGN_COUNT_LONG = 4'b0010,
		ILSS_OP_OR = 4'b0011,
		ILSS_OP_SATURATING_ADD_OP = 4'b0100,
		ILSS_OP_SATURATING_ADD_OP_LONG = 4'b0101,
		ILSS_OP_CLAMP = 4'b0110,
		ILSS_OP_SET = 4'b0111,
		ILSS_OP_SHL = 4'b1000,
		ILSS_OP_SHL_LONG = 4'b1001,
		ILSS_OP_SHL_UWORD_LONG = 4'b1010,
		ILSS_OP_NOT = 4'b1011
	} ilss_op_t;

endpackage : ilss_pkg

// *** ilss_sign_count.sv ***
`timescale 1ns/1ns
`default_nettype none

// counts the unbroken run of bits below the top bit that equal the top bit
module ilss_sign_count #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] value,
	output logic [5:0] count
);
	import ilss_pkg::*;

	logic run;

	// walk down from the bit under the sign until the first differing bit
	always_comb begin
		run = 1'b1;
		count = 6'h00;
		for (int i = WIDTH - 2; i >= 0; i--) begin
			if (run && (value[i] == value[WIDTH-1])) begin
				count = count + 6'h01;
			end else begin
				run = 1'b0;
			end
		end
	end

endmodule : ilss_sign_count

`default_nettype wire

// *** ilss_shift_left.sv ***
`timescale 1ns/1ns
`default_nettype none

// 40-bit left shifter, zero fill, amount capped at 40
module ilss_shift_left (
	input wire logic [39:0] value,
	input wire logic [5:0] amount,
	output logic [39:0] result
);
	import ilss_pkg::*;

	logic [5:0] amt_eff;

	// any amount 40..63 behaves as 40, which empties a long completely
	always_comb begin
		amt_eff = (amount > ILSS_SHIFT_LAST) ? ILSS_SHIFT_CAP : amount;
		result = value << amt_eff;
	end

endmodule : ilss_shift_left

`default_nettype wire

// *** ilss_rf_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// destination register of the register file, filled by write-back
module ilss_rf_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wb_valid,
	input wire logic [39:0] wb_data,
	output logic [39:0] dest_r
);
	// a skipped write-back leaves the old value for the bench to see
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) dest_r <= 40'h0;
		else if (wb_valid) dest_r <= wb_data;
	end
endmodule : ilss_rf_model

`default_nettype wire

// *** ilss_unit_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module ilss_unit_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic iss_valid,
	input wire logic [3:0] iss_op,
	input wire logic iss_pred,
	input wire logic iss_imm,
	input wire logic [4:0] iss_cst_a,
	input wire logic [4:0] iss_cst_b,
	input wire logic [39:0] first_source,
	input wire logic [39:0] second_source,
	input wire logic wb_valid,
	input wire logic wb_long,
	input wire logic [39:0] wb_data,
	input wire logic clip_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic go;
	logic [32:0] sum;
	logic [39:0] shl_r;
	logic [31:0] or_r;
	logic [31:0] not_r;
	// one spare bit shows word overflow as differing top bits
	assign go = iss_valid && iss_pred;
	assign sum = {first_source[31], first_source[31:0]} + {second_source[31], second_source[31:0]};
	// expected results one cycle on; shifts of 40 or more leave zero
	always_ff @(posedge pclk) begin
		shl_r <= second_source << first_source[5:0];
		or_r <= first_source[31:0] | second_source[31:0];
		not_r <= ~second_source[31:0];
	end
	a_or_bits: assert property (go && iss_op == 4'h3 && !iss_imm |=>
		wb_valid && wb_data == {8'h0, or_r}) else $error("or result wrong");
	a_not_bits: assert property (go && iss_op == 4'hb |=>
		wb_data == {8'h0, not_r}) else $error("invert result wrong");
	a_pred_hold: assert property (iss_valid && !iss_pred |=>
		!wb_valid && $stable(wb_data)) else $error("false predicate wrote");
	a_clip_after: assert property ($rose(clip_flag) |-> $past(wb_valid))
		else $error("clip not after write");
	a_clip_set: assert property (go && iss_op == 4'h4 && !iss_imm && sum[32] != sum[31] |=>
		##1 clip_flag) else $error("clip not set");
	a_saturating_add_op_max: assert property (go && iss_op == 4'h4 && !iss_imm && sum[32:31] == 2'b01 |=>
		wb_data == 40'h007fffffff) else $error("word add not clamped");
	a_clamp_high: assert property (go && iss_op == 4'h6 && !second_source[39] &&
		second_source[38:31] != 8'h0 |=> wb_data[31:0] == 32'h7fffffff) else $error("clamp high");
	a_shl_long: assert property (go && iss_op == 4'h9 && !iss_imm |=>
		wb_data == shl_r) else $error("long shift wrong");
	a_sign_zero: assert property (go && iss_op == 4'h1 &&
		second_source[31] != second_source[30] |=> wb_data == 40'h0)
		else $error("sign count not zero");
	a_long_flag: assert property (go && iss_op inside {4'h5, 4'h9, 4'ha} |=>
		wb_valid && wb_long) else $error("long result not flagged");
	a_word_flag: assert property (go && iss_op inside {4'h3, 4'h4, 4'hb} |=>
		!wb_long && wb_data[39:32] == 8'h0) else $error("word result not zero-extended");
endmodule : ilss_unit_chk

bind ilss_unit ilss_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .iss_valid(iss_valid), .iss_op(iss_op),
	.iss_pred(iss_pred), .iss_imm(iss_imm), .iss_cst_a(iss_cst_a), .iss_cst_b(iss_cst_b),
	.first_source(first_source), .second_source(second_source), .wb_valid(wb_valid),
	.wb_long(wb_long), .wb_data(wb_data), .clip_flag(clip_flag));

`default_nettype wire

// *** ilss_unit_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module ilss_unit_bench;
	import ilss_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic iss_valid = 1'b0;
	logic iss_pred = 1'b0;
	logic iss_imm = 1'b0;
	logic [3:0] iss_op = 4'h0;
	logic [4:0] iss_cst_a = 5'h0;
	logic [4:0] iss_cst_b = 5'h0;
	logic [39:0] first_source = 40'h0;
	logic [39:0] second_source = 40'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, wb_valid, wb_long, clip_flag, err_b;
	logic [39:0] wb_data, dest_r;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;

	ilss_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .iss_valid(iss_valid), .iss_op(iss_op), .iss_pred(iss_pred),
		.iss_imm(iss_imm), .iss_cst_a(iss_cst_a), .iss_cst_b(iss_cst_b),
		.first_source(first_source), .second_source(second_source), .wb_valid(wb_valid),
		.wb_long(wb_long), .wb_data(wb_data), .clip_flag(clip_flag));
	ilss_rf_model rf (.pclk(pclk), .presetn(presetn), .wb_valid(wb_valid), .wb_data(wb_data),
		.dest_r(dest_r));

	always #5 pclk = ~pclk;

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// a hung handshake must still reach the report
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			close_out();
		end
	end

	task automatic chk(input logic [39:0] got, input logic [39:0] ex);
		n_checks++;
		if (got !== ex) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask : chk

	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err_b = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one instruction; result judged in the register file after write-back
	task automatic iss(input logic [3:0] op, input logic pr, input logic im, input logic [4:0] a,
		input logic [4:0] b, input logic [39:0] s1, input logic [39:0] s2, input logic [39:0] ex);
		@(posedge pclk);
		iss_valid <= 1'b1;
		iss_op <= op;
		iss_pred <= pr;
		iss_imm <= im;
		iss_cst_a <= a;
		iss_cst_b <= b;
		first_source <= s1;
		second_source <= s2;
		@(posedge pclk);
		iss_valid <= 1'b0;
		@(posedge pclk);
		#1 chk(dest_r, ex);
	endtask : iss

	// control status read; writing 3 clears clip and keeps enable
	task automatic control_status_register(input logic [31:0] ex);
		apb(1'b0, ILSS_OFF_CSR, 32'h0);
		chk({8'h0, rd}, {8'h0, ex});
		apb(1'b1, ILSS_OFF_CSR, 32'h3);
	endtask : control_status_register

	task automatic t_count;
		iss(ILSS_OP_SIGN_COUNT, 1, 0, 0, 0, 0, 40'h02a3469f, 40'h5);
		iss(ILSS_OP_SIGN_COUNT, 1, 0, 0, 0, 0, 40'hfffff25a, 40'h13);
		iss(ILSS_OP_SIGN_COUNT, 1, 0, 0, 0, 0, 40'h40000000, 40'h0);
		iss(ILSS_OP_SIGN_COUNT, 1, 0, 0, 0, 0, 40'hffffffff, 40'h1f);
		iss(ILSS_OP_SIGN_COUNT, 1, 0, 0, 0, 0, 40'h0, 40'h1f);
	endtask : t_count

	task automatic t_logic;
		iss(ILSS_OP_OR, 1, 0, 0, 0, 40'h08a3a49f, 40'h00ff375a, 40'h08ffb7df);
		iss(ILSS_OP_OR, 1, 1, 5'h14, 0, 0, 40'h00003a41, 40'hfffffff5);
		iss(ILSS_OP_NOT, 1, 0, 0, 0, 0, 40'h29e3d31c, 40'hd61c2ce3);
		iss(ILSS_OP_OR, 0, 0, 0, 0, 40'h1, 40'h2, 40'hd61c2ce3);
	endtask : t_logic

	task automatic t_sat;
		control_status_register(32'h1);
		iss(ILSS_OP_SATURATING_ADD_OP, 1, 0, 0, 0, 40'h7fffffff, 40'h1, 40'h7fffffff);
		control_status_register(32'h3);
		iss(ILSS_OP_SATURATING_ADD_OP, 1, 0, 0, 0, 40'h80000000, 40'hffffffff, 40'h80000000);
		iss(ILSS_OP_SATURATING_ADD_OP, 1, 1, 5'h1f, 0, 0, 40'h80000000, 40'h80000000);
		iss(ILSS_OP_SATURATING_ADD_OP_LONG, 1, 0, 0, 0, 40'h1, 40'h7fffffffff, 40'h7fffffffff);
		iss(ILSS_OP_SATURATING_ADD_OP_LONG, 1, 0, 0, 0, 40'hffffffff, 40'h8000000000, 40'h8000000000);
		iss(ILSS_OP_CLAMP, 1, 0, 0, 0, 0, 40'h0100000000, 40'h7fffffff);
		iss(ILSS_OP_CLAMP, 1, 0, 0, 0, 0, 40'hff00000000, 40'h80000000);
		control_status_register(32'h3);
		iss(ILSS_OP_CLAMP, 1, 0, 0, 0, 0, 40'hff80001234, 40'h80001234);
		control_status_register(32'h1);
	endtask : t_sat

	task automatic t_set;
		iss(ILSS_OP_SET, 1, 1, 5'd7, 5'd21, 0, 40'h4b134a1e, 40'h4b3fff9e);
		// upper 22 bits of the field word kept clear by the issuer
		iss(ILSS_OP_SET, 1, 0, 0, 0, 40'h197, 40'h9ed31a31, 40'h9efffa31);
	endtask : t_set

	task automatic t_shift;
		iss(ILSS_OP_SHL, 1, 1, 5'd4, 0, 0, 40'h29e3d31c, 40'h9e3d31c0);
		iss(ILSS_OP_SHL, 1, 0, 0, 0, 40'h9, 40'h419751a5, 40'h2ea34a00);
		iss(ILSS_OP_SHL_LONG, 1, 0, 0, 0, 40'h22, 40'h09419751a5, 40'h9400000000);
		iss(ILSS_OP_SHL_LONG, 1, 0, 0, 0, 40'h27, 40'h09419751a5, 40'h8000000000);
		iss(ILSS_OP_SHL_LONG, 1, 0, 0, 0, 40'hfffffffc4, 40'h09419751a5, 40'h9419751a50);
		iss(ILSS_OP_SHL_LONG, 1, 0, 0, 0, 40'h3f, 40'h09419751a5, 40'h0);
	endtask : t_shift

	// long forms, result readback, counters, and the enable gate
	task automatic t_regs;
		iss(ILSS_OP_SIGN_COUNT_LONG, 1, 0, 0, 0, 0, 40'hffffffffff, 40'h27);
		iss(ILSS_OP_SIGN_COUNT_LONG, 1, 0, 0, 0, 0, 40'h0040000000, 40'h8);
		iss(ILSS_OP_SHL_UWORD_LONG, 1, 0, 0, 0, 40'h8, 40'h80000001, 40'h8000000100);
		apb(1'b0, ILSS_OFF_RES_HI, 32'h0);
		chk({8'h0, rd}, 40'h80);
		apb(1'b0, ILSS_OFF_RES_LO, 32'h0);
		chk({8'h0, rd}, 40'h100);
		apb(1'b1, ILSS_OFF_ISSUE_CNT, 32'h0);
		apb(1'b1, ILSS_OFF_SAT_CNT, 32'h0);
		// a false predicate must neither write nor raise clip
		iss(ILSS_OP_SATURATING_ADD_OP, 0, 0, 0, 0, 40'h7fffffff, 40'h1, 40'h8000000100);
		control_status_register(32'h1);
		iss(ILSS_OP_CLAMP, 1, 0, 0, 0, 0, 40'h0100000000, 40'h7fffffff);
		apb(1'b0, ILSS_OFF_ISSUE_CNT, 32'h0);
		chk({8'h0, rd}, 40'h1);
		apb(1'b0, ILSS_OFF_SAT_CNT, 32'h0);
		chk({8'h0, rd}, 40'h1);
		control_status_register(32'h3);
		// with the unit disabled an instruction is dropped
		apb(1'b1, ILSS_OFF_CSR, 32'h0);
		iss(ILSS_OP_SET, 1, 1, 5'd0, 5'd31, 0, 40'h0, 40'h7fffffff);
		apb(1'b1, ILSS_OFF_CSR, 32'h1);
		control_status_register(32'h1);
	endtask : t_regs

	// reset, an unmapped read, then each group of operations
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h0ff, 32'h0);
		chk({7'h0, err_b, rd}, 40'h100000000);
		t_count();
		t_logic();
		t_sat();
		t_set();
		t_shift();
		t_regs();
		close_out();
	end
endmodule : ilss_unit_bench

`default_nettype wire
